// file: pkg/rcb_pkg.sv
package rcb_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  REG_LIMIT        = 8'h00;
    localparam logic [7:0]  REG_EVAL         = 8'h04;
    localparam logic [7:0]  REG_RANGE        = 8'h08;
    localparam logic [7:0]  REG_STATUS       = 8'h0c;
    localparam logic [7:0]  REG_INSPECT      = 8'h10;

    // ==========================================================
    // Field positions
    localparam int          EVAL_NUM_LSB     = 0;
    localparam int          EVAL_UP_BIT      = 8;
    localparam int          EVAL_DN_BIT      = 9;
    localparam int          EVAL_RST_BIT     = 10;
    localparam int          EVAL_BIN_BIT     = 11;
    localparam int          RANGE_FIRST_LSB  = 0;
    localparam int          RANGE_LAST_LSB   = 16;
    localparam int          RANGE_BIN_BIT    = 31;
    localparam int          STAT_ERR_BIT     = 0;
    localparam int          STAT_BUSY_BIT    = 1;
    localparam int          STAT_FLAG_BIT    = 2;
    localparam int          STAT_COUNT_LSB   = 16;
    localparam int          INSP_FLAG_BIT    = 16;
    localparam int          INSP_PEND_BIT    = 17;
    localparam int          INSP_BIN_BIT     = 18;

    // ==========================================================
    // Reset values and codes
    localparam logic [15:0] LIMIT_RESET      = 16'h0000;
    localparam logic [15:0] MAX_BCD          = 16'h9999;
    localparam logic [15:0] MAX_BIN          = 16'hffff;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic {RCB_IDLE, RCB_WALK} rcb_state_t;

endpackage : rcb_pkg

// file: rtl/rcb_bcd_check.sv
`timescale 1ns/1ps
module rcb_bcd_check #(
    parameter int DIGITS = 4
) (
    input  wire logic [4*DIGITS-1:0] value,
    output      logic                valid
);
    logic [DIGITS-1:0] digit_ok;

    // ==========================================================
    // One comparator per decimal digit
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : g_digit
            assign digit_ok[g] = (value[g*4 +: 4] <= 4'h9);
        end
    endgenerate

    assign valid = &digit_ok;

endmodule : rcb_bcd_check

// file: rtl/rcb_counter_bank.sv
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// - BCD eval with non-BCD limit raises error
// - Rising up input adds, rising down subtracts
// - Count stays between zero and limit
// - Up from limit wraps to zero, flags
// - Down from zero wraps to limit, flags
// - Both inputs rising leaves count unchanged
// - Reset input zeroes count, ignores counting
// - Flag set only by a wrap
// - Range indices are timer or counter 0-255
// - Range reset clears flags first through last
// - Range reset loads maximum code
// - Next evaluation reloads limit after range reset
// - Mixed timer/counter range raises error
// - First above last clears one flag only
// - Unnumbered timers untouched by range reset
// - Variant touches only entries of its format
module rcb_counter_bank
    import rcb_pkg::*;
#(
    parameter int ADDR_W  = 8,
    parameter int NUM_W   = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    output      logic [1:0]        s_axi_bresp,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output      logic              error_flag
);
    localparam int NUM   = 1 << NUM_W;
    localparam int IDX_W = NUM_W + 1;
    // ==========================================================
    // Entry storage: index msb set means counter area
    logic [15:0]       count_mem [0:2*NUM-1];
    logic              flag_mem  [0:2*NUM-1];
    logic              pend_mem  [0:2*NUM-1];
    logic              bin_mem   [0:2*NUM-1];
    logic              up_prev   [0:NUM-1];
    logic              dn_prev   [0:NUM-1];
    logic [15:0]       limit_value;
    logic [15:0]       last_count;
    logic              last_flag;
    logic [IDX_W-1:0]  inspect_idx;
    rcb_state_t        state;
    logic [IDX_W-1:0]  walk_idx;
    logic [IDX_W-1:0]  walk_last;
    logic              walk_bin;
    // ==========================================================
    // Bus slave state
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    assign s_axi_awready = ~aw_full;
    assign s_axi_wready  = ~w_full;
    assign s_axi_arready = ~s_axi_rvalid;
    // Commands wait while a range walk owns the entry memory
    wire               busy     = (state == RCB_WALK);
    wire               wr_fire  = aw_full & w_full & ~s_axi_bvalid & ~busy;
    wire               rd_fire  = s_axi_arvalid & s_axi_arready;
    wire [7:0]         wr_addr  = aw_addr_q[7:0];
    wire [7:0]         rd_addr  = s_axi_araddr[7:0];
    wire               hit_lim  = (wr_addr == REG_LIMIT);
    wire               hit_eval = (wr_addr == REG_EVAL);
    wire               hit_rng  = (wr_addr == REG_RANGE);
    wire               hit_insp = (wr_addr == REG_INSPECT);
    wire               wr_ok    = hit_lim | hit_eval | hit_rng | hit_insp;
    wire               rd_ok    = (rd_addr == REG_LIMIT) | (rd_addr == REG_STATUS)
                                | (rd_addr == REG_INSPECT);
    wire               eval_fire = wr_fire & hit_eval;
    wire               rr_fire   = wr_fire & hit_rng;
    // ==========================================================
    // Evaluation decode
    wire [NUM_W-1:0]   e_num   = w_data_q[EVAL_NUM_LSB +: NUM_W];
    wire [IDX_W-1:0]   e_idx   = {1'b1, e_num};
    wire               e_up    = w_data_q[EVAL_UP_BIT];
    wire               e_dn    = w_data_q[EVAL_DN_BIT];
    wire               e_rst   = w_data_q[EVAL_RST_BIT];
    wire               e_bin   = w_data_q[EVAL_BIN_BIT];
    logic              limit_ok;
    rcb_bcd_check #(
        .DIGITS (4)
    ) u_limit_check (
        .value  (limit_value),
        .valid  (limit_ok)
    );
    wire               e_err   = ~e_bin & ~limit_ok;
    wire               rise_up = e_up & ~up_prev[e_num];
    wire               rise_dn = e_dn & ~dn_prev[e_num];
    wire               step_up = rise_up & ~rise_dn;
    wire               step_dn = rise_dn & ~rise_up;
    wire [15:0]        cur     = count_mem[e_idx];
    // Pending entry reloads limit; clamp above limit
    wire [15:0]        base    = (pend_mem[e_idx] | (cur > limit_value)) ? limit_value : cur;
    wire               wrap_up = step_up & (base == limit_value);
    wire               wrap_dn = step_dn & (base == 16'h0000);
    function automatic logic [15:0] rcb_step(input logic [15:0] v, input logic bcd,
                                             input logic up);
        logic [15:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        if (!bcd) begin
            r = up ? v + 16'h0001 : v - 16'h0001;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (c) begin
                    if (up && v[i*4 +: 4] == 4'h9) begin
                        r[i*4 +: 4] = 4'h0;
                    end else if (!up && v[i*4 +: 4] == 4'h0) begin
                        r[i*4 +: 4] = 4'h9;
                    end else begin
                        r[i*4 +: 4] = up ? v[i*4 +: 4] + 4'h1 : v[i*4 +: 4] - 4'h1;
                        c = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : rcb_step
    logic [15:0]       next_count;
    logic              next_flag;
    always_comb begin
        next_count = base;
        next_flag  = flag_mem[e_idx] & ~pend_mem[e_idx];
        if (e_rst) begin
            next_count = 16'h0000;
            next_flag  = 1'b0;
        end else if (step_up) begin
            next_count = wrap_up ? 16'h0000 : rcb_step(base, ~e_bin, 1'b1);
            next_flag  = wrap_up;
        end else if (step_dn) begin
            next_count = wrap_dn ? limit_value : rcb_step(base, ~e_bin, 1'b0);
            next_flag  = wrap_dn;
        end
    end
    // ==========================================================
    // Range reset decode
    wire [IDX_W-1:0]   r_first    = w_data_q[RANGE_FIRST_LSB +: IDX_W];
    wire [IDX_W-1:0]   r_last     = w_data_q[RANGE_LAST_LSB +: IDX_W];
    wire               r_bin      = w_data_q[RANGE_BIN_BIT];
    wire               r_area_err = (r_first[IDX_W-1] != r_last[IDX_W-1]);
    wire               r_single   = (r_first > r_last);
    wire               walk_hit   = busy & (bin_mem[walk_idx] == walk_bin);
    wire               walk_end   = busy & (walk_idx == walk_last);
    wire [15:0]        max_code   = walk_bin ? MAX_BIN : MAX_BCD;
    // ==========================================================
    // Bus channels
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr_q    <= '0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // Reads are answered from live state, one cycle after the address
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= 32'h0000_0000;
            if (rd_addr == REG_LIMIT) begin
                s_axi_rdata[15:0] <= limit_value;
            end else if (rd_addr == REG_STATUS) begin
                s_axi_rdata[STAT_ERR_BIT]            <= error_flag;
                s_axi_rdata[STAT_BUSY_BIT]           <= busy;
                s_axi_rdata[STAT_FLAG_BIT]           <= last_flag;
                s_axi_rdata[STAT_COUNT_LSB +: 16]    <= last_count;
            end else if (rd_addr == REG_INSPECT) begin
                s_axi_rdata[15:0]          <= count_mem[inspect_idx];
                s_axi_rdata[INSP_FLAG_BIT] <= flag_mem[inspect_idx];
                s_axi_rdata[INSP_PEND_BIT] <= pend_mem[inspect_idx];
                s_axi_rdata[INSP_BIN_BIT]  <= bin_mem[inspect_idx];
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Control registers and range walk
    always_ff @(posedge clk) begin
        if (rst) begin
            limit_value <= LIMIT_RESET;
            inspect_idx <= '0;
            error_flag  <= 1'b0;
            last_count  <= 16'h0000;
            last_flag   <= 1'b0;
            state       <= RCB_IDLE;
            walk_idx    <= '0;
            walk_last   <= '0;
            walk_bin    <= 1'b0;
        end else begin
            if (wr_fire && hit_lim && w_strb_q[0]) limit_value[7:0]  <= w_data_q[7:0];
            if (wr_fire && hit_lim && w_strb_q[1]) limit_value[15:8] <= w_data_q[15:8];
            if (wr_fire && hit_insp) inspect_idx <= w_data_q[IDX_W-1:0];
            if (eval_fire) begin
                error_flag <= e_err;
                if (!e_err) begin
                    last_count <= next_count;
                    last_flag  <= next_flag;
                end
            end
            if (rr_fire) begin
                error_flag <= r_area_err;
                if (!r_area_err && !r_single) begin
                    state     <= RCB_WALK;
                    walk_idx  <= r_first;
                    walk_last <= r_last;
                    walk_bin  <= r_bin;
                end
            end
            case (state)
                RCB_IDLE: begin
                end
                RCB_WALK: begin
                    if (walk_end) begin
                        state <= RCB_IDLE;
                    end else begin
                        walk_idx <= walk_idx + IDX_W'(1);
                    end
                end
                default: state <= RCB_IDLE;
            endcase
        end
    end
    // ==========================================================
    // Entry memory; one entry changes per cycle at most
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2*NUM; i++) begin
                count_mem[i] <= 16'h0000;
                flag_mem[i]  <= 1'b0;
                pend_mem[i]  <= 1'b0;
                bin_mem[i]   <= 1'b0;
            end
            for (int i = 0; i < NUM; i++) begin
                up_prev[i] <= 1'b0;
                dn_prev[i] <= 1'b0;
            end
        end else begin
            if (eval_fire) begin
                // Samples kept for next edge check
                up_prev[e_num] <= e_up;
                dn_prev[e_num] <= e_dn;
                if (!e_err) begin
                    count_mem[e_idx] <= next_count;
                    flag_mem[e_idx]  <= next_flag;
                    pend_mem[e_idx]  <= 1'b0;
                    bin_mem[e_idx]   <= e_bin;
                end
            end
            if (rr_fire && !r_area_err && r_single && bin_mem[r_first] == r_bin) begin
                flag_mem[r_first] <= 1'b0;
            end
            // Walk clears matching entries; bank has only numbered ones
            if (walk_hit) begin
                flag_mem[walk_idx]  <= 1'b0;
                count_mem[walk_idx] <= max_code;
                pend_mem[walk_idx]  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ev_ok = eval_fire & ~e_err & ~e_rst;
    sequence walk_start_s;
        rr_fire && !r_area_err && !r_single;
    endsequence
    sequence walk_last_s;
        busy && walk_idx == walk_last;
    endsequence
    bcd_error_a: assert property (eval_fire && e_err |=> error_flag && $stable(last_count))
        else $error("bad BCD limit not flagged");
    up_step_a: assert property (ev_ok && step_up && !wrap_up && e_bin
        |=> last_count == $past(base) + 16'h0001 && !last_flag)
        else $error("binary up step wrong");
    count_range_a: assert property (ev_ok |=> last_count <= $past(limit_value))
        else $error("count above limit");
    wrap_up_a: assert property (ev_ok && wrap_up |=> last_count == 16'h0000 && last_flag)
        else $error("up wrap wrong");
    wrap_down_a: assert property (ev_ok && wrap_dn
        |=> last_count == $past(limit_value) && last_flag)
        else $error("down wrap wrong");
    both_hold_a: assert property (ev_ok && rise_up && rise_dn
        |=> last_count == $past(base))
        else $error("count moved on double edge");
    reset_zero_a: assert property (eval_fire && !e_err && e_rst
        |=> last_count == 16'h0000 && !last_flag)
        else $error("reset input ignored");
    flag_cause_a: assert property (ev_ok && (step_up || step_dn) && !wrap_up && !wrap_dn
        |=> !last_flag)
        else $error("flag without wrap");
    walk_begin_a: assert property (walk_start_s |=> busy && walk_idx == $past(r_first))
        else $error("range walk not started");
    walk_stop_a: assert property (walk_last_s |=> !busy)
        else $error("range walk overran");
    max_load_a: assert property (walk_hit
        |=> count_mem[$past(walk_idx)] == $past(max_code) && !flag_mem[$past(walk_idx)])
        else $error("range reset value wrong");
    limit_reload_a: assert property (ev_ok && pend_mem[e_idx] && !rise_up && !rise_dn
        |=> last_count == $past(limit_value))
        else $error("no reload after range reset");
    area_err_a: assert property (rr_fire && r_area_err |=> error_flag && !busy)
        else $error("mixed range accepted");
    single_clear_a: assert property (rr_fire && !r_area_err && r_single
        |=> !busy && !error_flag)
        else $error("reversed range walked");
endmodule : rcb_counter_bank

// file: verification/rcb_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// Controlling program: AXI4-Lite master toward the counter bank
module rcb_ctrl_model (
    input  wire logic        clk,
    output      logic [7:0]  awaddr,
    output      logic        awvalid,
    input  wire logic        awready,
    output      logic [31:0] wdata,
    output      logic [3:0]  wstrb,
    output      logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output      logic        bready,
    output      logic [7:0]  araddr,
    output      logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output      logic        rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
    end

    // Address and data are driven together; each valid drops once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_p;
        logic w_p;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_p = 1'b1;
        w_p  = 1'b1;
        do begin
            @(posedge clk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end while (aw_p || w_p);
        while (!bvalid) @(posedge clk);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : rcb_ctrl_model

// file: verification/reversible_counter_bank_with_range_reset_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module reversible_counter_bank_with_range_reset_bench;
    import rcb_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, error_flag;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    rcb_counter_bank dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .error_flag(error_flag));

    rcb_ctrl_model m (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ==========================================================
    // Access tasks; ctl is {binary, reset, down, up}
    task automatic ev(input logic [7:0] n, input logic [3:0] ctl);
        m.wr(REG_EVAL, {20'h00000, ctl, n}, rsp);
    endtask : ev

    // Rising evaluation then a low one, so the next call sees a fresh edge
    task automatic pulse(input logic [7:0] n, input logic [3:0] ctl);
        ev(n, ctl);
        ev(n, ctl & 4'h8);
    endtask : pulse

    task automatic stat(input logic [15:0] c, input logic f);
        m.rd(REG_STATUS, rdv, rsp);
        `CHK(rdv[31:16], c)
        `CHK(rdv[2], f)
    endtask : stat

    // bpf is {binary, reload pending, flag}
    task automatic insp(input logic [8:0] i, input logic [15:0] c, input logic [2:0] bpf);
        m.wr(REG_INSPECT, {23'h000000, i}, rsp);
        m.rd(REG_INSPECT, rdv, rsp);
        `CHK(rdv[15:0], c)
        `CHK(rdv[18:16], bpf)
    endtask : insp

    // Walks here cover at most three entries, so 20 status polls are enough
    task automatic rng(input logic b, input logic [8:0] f, input logic [8:0] l);
        m.wr(REG_RANGE, {b, 6'h00, l, 7'h00, f}, rsp);
        for (int k = 0; k < 20; k++) begin
            m.rd(REG_STATUS, rdv, rsp);
            if (rdv[1] === 1'b0) break;
        end
        `CHK(rdv[1], 1'b0)
    endtask : rng

    task automatic tally_and_finish;
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        m.rd(REG_STATUS, rdv, rsp);
        `CHK(rdv, 32'h00000000)
        m.rd(REG_LIMIT, rdv, rsp);
        `CHK(rdv[15:0], LIMIT_RESET)
        m.wr(8'h14, 32'h00000001, rsp);
        `CHK(rsp, RESP_SLVERR)
        m.wr(REG_STATUS, 32'h00000001, rsp);
        `CHK(rsp, RESP_SLVERR)
        m.rd(REG_EVAL, rdv, rsp);
        `CHK(rsp, RESP_SLVERR)
        m.rd(8'h14, rdv, rsp);
        `CHK(rdv, 32'h00000000)
        // limits stay in range, one user per counter number
        m.wr(REG_LIMIT, 32'h00000003, rsp);
        `CHK(rsp, RESP_OKAY)
        ev(8'h05, 4'h4);
        stat(16'h0000, 1'b0);
        for (int i = 1; i <= 3; i++) begin
            pulse(8'h05, 4'h1);
            stat(16'(i), 1'b0);
        end
        pulse(8'h05, 4'h1);
        stat(16'h0000, 1'b1);
        pulse(8'h05, 4'h1);
        stat(16'h0001, 1'b0);
        pulse(8'h05, 4'h2);
        stat(16'h0000, 1'b0);
        pulse(8'h05, 4'h2);
        stat(16'h0003, 1'b1);
        pulse(8'h05, 4'h2);
        stat(16'h0002, 1'b0);
        pulse(8'h05, 4'h3);
        stat(16'h0002, 1'b0);
        pulse(8'h05, 4'h5);
        stat(16'h0000, 1'b0);
        ev(8'h05, 4'h1);
        ev(8'h06, 4'h1);
        stat(16'h0001, 1'b0);
        ev(8'h05, 4'h1);
        stat(16'h0001, 1'b0);
        ev(8'h06, 4'h0);
        m.wr(REG_LIMIT, 32'h000000a0, rsp);
        ev(8'h05, 4'h0);
        `CHK(error_flag, 1'b1)
        m.wr(REG_LIMIT, 32'h00000000, rsp);
        ev(8'h05, 4'h0);
        `CHK(error_flag, 1'b0)
        stat(16'h0000, 1'b0);
        // Decimal borrow and carry across a digit, then the same steps in binary
        m.wr(REG_LIMIT, 32'h00000010, rsp);
        ev(8'h08, 4'h4);
        pulse(8'h08, 4'h2);
        pulse(8'h08, 4'h2);
        stat(16'h0009, 1'b0);
        pulse(8'h08, 4'h1);
        stat(16'h0010, 1'b0);
        ev(8'h09, 4'hc);
        pulse(8'h09, 4'ha);
        pulse(8'h09, 4'ha);
        stat(16'h000f, 1'b0);
        pulse(8'h09, 4'h9);
        stat(16'h0010, 1'b0);
        m.wr(REG_LIMIT, 32'h000000a0, rsp);
        ev(8'h07, 4'hc);
        pulse(8'h07, 4'ha);
        stat(16'h00a0, 1'b1);
        `CHK(error_flag, 1'b0)
        m.wr(REG_LIMIT, 32'h00000003, rsp);
        rng(1'b0, 9'h105, 9'h107);
        insp(9'h105, MAX_BCD, 3'b010);
        insp(9'h106, MAX_BCD, 3'b010);
        insp(9'h107, 16'h00a0, 3'b101);
        `CHK(error_flag, 1'b0)
        ev(8'h05, 4'h0);
        stat(16'h0003, 1'b0);
        insp(9'h105, 16'h0003, 3'b000);
        rng(1'b1, 9'h107, 9'h107);
        insp(9'h107, MAX_BIN, 3'b110);
        rng(1'b0, 9'h005, 9'h105);
        `CHK(error_flag, 1'b1)
        insp(9'h106, MAX_BCD, 3'b010);
        pulse(8'h05, 4'h1);
        pulse(8'h06, 4'h1);
        stat(16'h0000, 1'b1);
        rng(1'b0, 9'h106, 9'h105);
        insp(9'h106, 16'h0000, 3'b000);
        insp(9'h105, 16'h0000, 3'b001);
        tally_and_finish();
    end
endmodule : reversible_counter_bank_with_range_reset_bench
